// *** tws_status_flags.sv ***
// Purpose: status and flag logic of a two-wire bus controller
// Assumes: APB slave, pins sampled on pclk, shifter runs from bit counts
// Notes: master data path is minimal: drives the SDA bit given to it
`timescale 1ns/1ps
module tws_status_flags (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // two-wire pins (oe low drives the pin low)
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // cpu wait and interrupts
    input wire logic wait_instruction,
    output logic bus_irq,
    output logic evt_irq,
    output logic clocks_halted
);
    // ==========================================================
    // registers and wires
    tws_pkg::tws_line_type line;
    tws_pkg::tws_state_type state_r;
    tws_pkg::tws_state_type state_nxt;
    logic [7:0] ctrl_r;
    logic [7:0] saddr_r;
    logic [7:0] data_r;
    logic [7:0] shift_r;
    logic [3:0] bit_cnt_r;
    logic byte_transfer_complete_r;
    logic addressed_as_slave_r;
    logic bus_busy_flag_r;
    logic arbitration_lost_r;
    logic bus_interrupt_flag_r;
    logic slave_read_write_dir_r;
    logic rx_ack_r;
    logic stop_req_r;
    logic sda_drv_r;
    logic [4:0] evt_status;
    logic [4:0] evt_mask;

    // ==========================================================
    // apb decode
    wire acc = psel & penable & clk_en;
    wire wr = acc & pwrite;
    wire rd = acc & ~pwrite;
    wire hit_st = paddr == tws_pkg::ADDR_STATUS;
    wire hit_ct = paddr == tws_pkg::ADDR_CONTROL;
    wire hit_sa = paddr == tws_pkg::ADDR_SLAVE_ADDR;
    wire hit_dt = paddr == tws_pkg::ADDR_DATA;
    wire hit_ev = paddr == tws_pkg::ADDR_EVT;
    wire hit_em = paddr == tws_pkg::ADDR_EVT_MASK;
    wire hit_any = hit_st | hit_ct | hit_sa | hit_dt | hit_ev | hit_em;
    wire wr_st = wr & hit_st;
    wire wr_ct = wr & hit_ct;
    wire wr_dt = wr & hit_dt;

    // ==========================================================
    // control bits
    wire en = ctrl_r[tws_pkg::CT_EN];
    wire ie = ctrl_r[tws_pkg::CT_IE];
    wire master = ctrl_r[tws_pkg::CT_MS];
    wire tx = ctrl_r[tws_pkg::CT_TX];
    wire general_call_enable = ctrl_r[tws_pkg::CT_GENERAL_CALL_ENABLE];
    wire stop_in_wait_select = ctrl_r[tws_pkg::CT_SWAI];
    wire [7:0] wd = pwdata[7:0];

    // in wait with stop-in-wait set the engine freezes, else runs on
    wire halt = wait_instruction & stop_in_wait_select;
    wire run = clk_en & en & ~halt;

    // start request: master bit rising, or repeated start bit written
    wire start_req = wr_ct & wd[tws_pkg::CT_MS] & ~master;
    wire rsta_req = wr_ct & wd[tws_pkg::CT_RSTA];
    wire stop_cmd = wr_ct & ~wd[tws_pkg::CT_MS] & master;

    // ==========================================================
    // byte engine
    wire ninth_fall = line.scl_fall && bit_cnt_r == tws_pkg::BITS_PER_BYTE;
    wire in_byte = state_r == tws_pkg::TWS_ADDR ||
        state_r == tws_pkg::TWS_DATA;
    wire ack_slot = bit_cnt_r == (tws_pkg::BITS_PER_BYTE - 4'h1);
    wire own_match = shift_r[7:1] == saddr_r[7:1];
    wire gc_match = general_call_enable &&
        shift_r == tws_pkg::GEN_CALL_ADDR;
    wire addr_done = state_r == tws_pkg::TWS_ADDR && ninth_fall;
    wire match = addr_done & ~master & (own_match | gc_match);

    // sda high driven by us but line reads low: arbitration lost
    wire tx_cycle = master & tx & ~ack_slot;
    wire rx_ack = master & ~tx & ack_slot & sda_drv_r;
    wire sda_clash = line.scl_rise & sda_drv_r & ~line.sda & in_byte;
    wire lose_tx = sda_clash & tx_cycle;
    wire lose_rx = sda_clash & rx_ack;
    wire lose_busy = start_req & bus_busy_flag_r;
    wire lose_rsta = rsta_req & ~master;
    wire lose_stop = line.stop & master & ~stop_req_r;
    wire lose = run & (lose_tx | lose_rx | lose_busy | lose_rsta |
        lose_stop);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            tws_pkg::TWS_IDLE: begin
                if (line.start) begin
                    state_nxt = tws_pkg::TWS_ADDR;
                end
            end
            tws_pkg::TWS_ADDR: begin
                if (ninth_fall) begin
                    state_nxt = tws_pkg::TWS_DATA;
                end
            end
            tws_pkg::TWS_DATA: begin
                if (lose_tx | lose_rx) begin
                    state_nxt = tws_pkg::TWS_LOST;
                end
            end
            tws_pkg::TWS_LOST: begin
                state_nxt = tws_pkg::TWS_LOST;
            end
            default: begin
                state_nxt = tws_pkg::TWS_IDLE;
            end
        endcase
        if (line.stop) begin
            state_nxt = tws_pkg::TWS_IDLE;
        end else if (line.start) begin
            state_nxt = tws_pkg::TWS_ADDR;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= tws_pkg::TWS_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            sda_drv_r <= 1'b1;
        end else if (run) begin
            state_r <= state_nxt;
            if (line.start || ninth_fall) begin
                bit_cnt_r <= 4'h0;
            end else if (line.scl_rise && in_byte) begin
                bit_cnt_r <= bit_cnt_r + 4'h1;
            end
            if (line.scl_rise && in_byte && !ack_slot) begin
                shift_r <= {shift_r[6:0], line.sda};
            end else if (wr_dt) begin
                shift_r <= wd;
            end
            if (line.scl_fall) begin
                sda_drv_r <= master & tx ? shift_r[7] :
                    ~(master & ~tx & ~ctrl_r[tws_pkg::CT_TXAK]);
            end
        end
    end

    // ==========================================================
    // status flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            byte_transfer_complete_r <= 1'b1;
            addressed_as_slave_r <= 1'b0;
            bus_busy_flag_r <= 1'b0;
            arbitration_lost_r <= 1'b0;
            bus_interrupt_flag_r <= 1'b0;
            slave_read_write_dir_r <= 1'b0;
            rx_ack_r <= 1'b1;
            stop_req_r <= 1'b0;
            data_r <= 8'h00;
        end else if (clk_en) begin
            if (run && ninth_fall) begin
                byte_transfer_complete_r <= 1'b1;
                data_r <= shift_r;
            end else if (run && in_byte && line.scl_rise &&
                bit_cnt_r == 4'h0) begin
                byte_transfer_complete_r <= 1'b0;
            end
            // set wins over the control-write clear
            if (run && match) begin
                addressed_as_slave_r <= 1'b1;
                slave_read_write_dir_r <= shift_r[0];
            end else if (wr_ct) begin
                addressed_as_slave_r <= 1'b0;
            end
            if (run && line.start) begin
                bus_busy_flag_r <= 1'b1;
            end else if (run && line.stop) begin
                bus_busy_flag_r <= 1'b0;
            end
            if (lose) begin
                arbitration_lost_r <= 1'b1;
            end else if (wr_st && wd[tws_pkg::ST_ARB]) begin
                arbitration_lost_r <= 1'b0;
            end
            if (run && (ninth_fall | match | lose)) begin
                bus_interrupt_flag_r <= 1'b1;
            end else if (wr_st && wd[tws_pkg::ST_IF]) begin
                bus_interrupt_flag_r <= 1'b0;
            end
            if (run && line.scl_rise && ack_slot) begin
                rx_ack_r <= line.sda;
            end
            if (stop_cmd) begin
                stop_req_r <= 1'b1;
            end else if (line.stop) begin
                stop_req_r <= 1'b0;
            end
        end
    end

    // ==========================================================
    // control and address registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= tws_pkg::RST_CONTROL;
            saddr_r <= tws_pkg::RST_SLAVE_ADDR;
        end else if (clk_en) begin
            if (wr_ct) begin
                // repeated start is a strobe, never stored
                ctrl_r <= wd & ~(8'h01 << tws_pkg::CT_RSTA);
            end else if (lose) begin
                ctrl_r[tws_pkg::CT_MS] <= 1'b0;
            end
            if (wr & hit_sa) begin
                saddr_r <= wd;
            end
        end
    end

    // ==========================================================
    // events and interrupts
    wire [4:0] evt_set = run ? {line.stop, line.start, lose, match,
        ninth_fall} : 5'h00;

    tws_evt_irq u_evt (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .evt_set(evt_set),
        .evt_rd(rd & hit_ev),
        .mask_wr(wr & hit_em),
        .mask_wdata(pwdata[4:0]),
        .evt_status(evt_status),
        .evt_mask(evt_mask),
        .evt_irq(evt_irq)
    );

    tws_line_sense u_line (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .line(line)
    );

    // the level also wakes a cpu waiting with stop-in-wait clear once the operation ends
    assign bus_irq = bus_interrupt_flag_r & ie;
    assign clocks_halted = halt;

    // ==========================================================
    // read mux
    // direction bit is reported for software to pick the mode
    wire [7:0] status_w = {byte_transfer_complete_r,
        addressed_as_slave_r, bus_busy_flag_r, arbitration_lost_r,
        1'b0, slave_read_write_dir_r, bus_interrupt_flag_r,
        rx_ack_r};
    wire [31:0] rd_mux = hit_st ? {24'h000000, status_w} :
        hit_ct ? {24'h000000, ctrl_r} :
        hit_sa ? {24'h000000, saddr_r} :
        hit_dt ? {24'h000000, data_r} :
        hit_ev ? {27'h0000000, evt_status} :
        hit_em ? {27'h0000000, evt_mask} : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (clk_en && psel && !penable) begin
            prdata <= rd_mux;
        end
    end

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit_any;
    assign sda_out = 1'b0;
    assign sda_oe_n = sda_drv_r | ~en;
endmodule

// *** tws_pkg.sv ***
// Purpose: constants and types for the two-wire bus status and flag logic
// Assumes: APB slave with 32-bit data; 20 MHz pclk
// Notes: register offsets below are byte addresses
package tws_pkg;

    // ==========================================================
    // register map (byte addresses)
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_CONTROL = 8'h04;
    localparam logic [7:0] ADDR_SLAVE_ADDR = 8'h08;
    localparam logic [7:0] ADDR_DATA = 8'h0C;
    localparam logic [7:0] ADDR_EVT = 8'h10;
    localparam logic [7:0] ADDR_EVT_MASK = 8'h14;

    // ==========================================================
    // status bit positions
    localparam int ST_TCF = 7;
    localparam int ST_AAS = 6;
    localparam int ST_BUSY = 5;
    localparam int ST_ARB = 4;
    localparam int ST_RSV = 3;
    localparam int ST_SRW = 2;
    localparam int ST_IF = 1;
    localparam int ST_RXAK = 0;

    // control bit positions
    localparam int CT_EN = 7;
    localparam int CT_IE = 6;
    localparam int CT_MS = 5;
    localparam int CT_TX = 4;
    localparam int CT_TXAK = 3;
    localparam int CT_RSTA = 2;
    localparam int CT_GENERAL_CALL_ENABLE = 1;
    localparam int CT_SWAI = 0;

    // event bit positions (sticky, clear on read)
    localparam int EV_DONE = 0;
    localparam int EV_MATCH = 1;
    localparam int EV_ARB = 2;
    localparam int EV_START = 3;
    localparam int EV_STOP = 4;

    // ==========================================================
    // reset values, general call address and bits per byte
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_SLAVE_ADDR = 8'h00;
    localparam logic [4:0] RST_EVT_MASK = 5'h00;
    localparam logic [7:0] GEN_CALL_ADDR = 8'h00;
    localparam logic [3:0] BITS_PER_BYTE = 4'h9;

    // byte engine states, gray along idle-addr-data path
    typedef enum logic [1:0] {
        TWS_IDLE = 2'b00,
        TWS_ADDR = 2'b01,
        TWS_DATA = 2'b11,
        TWS_LOST = 2'b10
    } tws_state_type;

    // line conditions from the pin sampler
    typedef struct packed {
        logic start;
        logic stop;
        logic scl_rise;
        logic scl_fall;
        logic sda;
    } tws_line_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic write;
        logic sel;
        logic enable;
    } tws_apb_req_type;

endpackage

// *** tws_line_sense.sv ***
// Purpose: synchronise the bus pins and find clock edges and conditions
// Assumes: pins are asynchronous to pclk
// Notes: first sync stage is read only by the second
`timescale 1ns/1ps
module tws_line_sense (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // pins
    input wire logic scl_in,
    input wire logic sda_in,
    // decoded line
    output tws_pkg::tws_line_type line
);
    logic [1:0] scl_sync_r;
    logic [1:0] sda_sync_r;
    logic scl_d_r;
    logic sda_d_r;
    tws_pkg::tws_line_type line_r;

    wire scl_s = scl_sync_r[1];
    wire sda_s = sda_sync_r[1];
    wire rise_w = scl_s & ~scl_d_r;
    wire fall_w = ~scl_s & scl_d_r;
    wire start_w = scl_s & scl_d_r & sda_d_r & ~sda_s;
    wire stop_w = scl_s & scl_d_r & ~sda_d_r & sda_s;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_sync_r <= 2'h3;
            sda_sync_r <= 2'h3;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
            line_r <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
        end else if (clk_en) begin
            scl_sync_r <= {scl_sync_r[0], scl_in};
            sda_sync_r <= {sda_sync_r[0], sda_in};
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
            line_r <= '{start_w, stop_w, rise_w, fall_w, sda_s};
        end
    end

    assign line = line_r;
endmodule

// *** tws_evt_irq.sv ***
// Purpose: sticky event bits, mask and one level interrupt
// Assumes: read of the event register clears it
// Notes: a set in the clearing cycle wins
`timescale 1ns/1ps
module tws_evt_irq (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // events and access
    input wire logic [4:0] evt_set,
    input wire logic evt_rd,
    input wire logic mask_wr,
    input wire logic [4:0] mask_wdata,
    // state
    output logic [4:0] evt_status,
    output logic [4:0] evt_mask,
    output logic evt_irq
);
    logic [4:0] evt_r;
    logic [4:0] mask_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_r <= 5'h00;
            mask_r <= tws_pkg::RST_EVT_MASK;
        end else if (clk_en) begin
            evt_r <= (evt_rd ? 5'h00 : evt_r) | evt_set;
            if (mask_wr) begin
                mask_r <= mask_wdata;
            end
        end
    end

    assign evt_status = evt_r;
    assign evt_mask = mask_r;
    assign evt_irq = |(evt_r & mask_r);
endmodule

// *** tws_status_assertions.sv ***
// Purpose: port checks for the two-wire status block
// Assumes: pready is combinational, prdata valid in access phase
// Notes: bound to tws_status_flags at the foot of this file
`timescale 1ns/1ps
module tws_status_assertions (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // cpu side
    input wire logic wait_instruction,
    input wire logic bus_irq,
    input wire logic evt_irq,
    input wire logic clocks_halted
);
    // ========================================
    // decode
    wire acc = psel && penable;
    wire wr_go = acc && pwrite && clk_en;
    wire far = paddr > tws_pkg::ADDR_EVT_MASK;
    wire st_rd = acc && !pwrite && paddr == tws_pkg::ADDR_STATUS;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ========================================
    // sequences
    sequence ie_off_wr;
        wr_go && paddr == tws_pkg::ADDR_CONTROL && !pwdata[tws_pkg::CT_IE];
    endsequence
    sequence mask_off_wr;
        wr_go && paddr == tws_pkg::ADDR_EVT_MASK && pwdata[4:0] == 5'h00;
    endsequence

    access_ready_a: assert property (acc |-> pready)
        else $error("pready low in access phase");
    unmapped_err_a: assert property (acc && far |-> pslverr)
        else $error("no error on unmapped access");
    idle_no_err_a: assert property (!acc |-> !pslverr)
        else $error("pslverr outside access phase");
    unmapped_zero_a: assert property (acc && !pwrite && far |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    reserved_zero_a: assert property (st_rd |-> !prdata[tws_pkg::ST_RSV])
        else $error("reserved status bit set");
    status_width_a: assert property (st_rd |-> prdata[31:8] == 24'h0)
        else $error("status upper bits set");
    wait_run_a: assert property (!wait_instruction |-> !clocks_halted)
        else $error("clocks halted outside wait");
    irq_gate_a: assert property (ie_off_wr |=> !bus_irq [*2])
        else $error("irq with enable clear");
    mask_gate_a: assert property (mask_off_wr |=> !evt_irq)
        else $error("event irq with mask clear");
endmodule

bind tws_status_flags tws_status_assertions u_chk (.pclk(pclk),
    .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .wait_instruction(wait_instruction), .bus_irq(bus_irq),
    .evt_irq(evt_irq), .clocks_halted(clocks_halted));

// *** tws_bus_partner.sv ***
// Purpose: far-side master on the two-wire bus
// Assumes: open-drain lines with pull-ups, 400 ns link clock
// Notes: scl stands high between frames; sda released means high
`timescale 1ns/1ps
module tws_bus_partner (
    // wire drive
    output logic scl,
    output logic sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // sda falls while scl high
    task automatic send_start();
        // keep pin edges off the pclk sampling edge
        #10;
        sda_low = 1'b1;
        #200;
        scl = 1'b0;
        #100;
    endtask
    // msb first, ninth clock leaves sda to the slave
    task automatic send_byte(input logic [7:0] b);
        for (int i = 0; i < 9; i++) begin
            sda_low = (i < 8) ? !b[7 - i] : 1'b0;
            #100;
            scl = 1'b1;
            #200;
            scl = 1'b0;
            #100;
        end
    endtask
    // sda rises while scl high
    task automatic send_stop();
        #10;
        sda_low = 1'b1;
        #100;
        scl = 1'b1;
        #100;
        sda_low = 1'b0;
        #200;
    endtask
endmodule

// *** i2c_status_flag_logic_tb.sv ***
// Purpose: register level test of the two-wire status block
// Assumes: zero wait state apb, pins synced in a few pclk
// Notes: clk_en is tied high
`timescale 1ns/1ps
module i2c_status_flag_logic_tb;
    logic pclk, presetn, psel, penable, pwrite, wait_instruction;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, sda_out, sda_oe_n, err;
    logic bus_irq, evt_irq, clocks_halted, scl, sda_low;
    int mismatches;
    int compares;
    // pull-up wire: low if either party pulls
    wire sda_line = !(sda_low || !sda_oe_n);

    tws_status_flags dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .wait_instruction(wait_instruction), .bus_irq(bus_irq),
        .evt_irq(evt_irq), .clocks_halted(clocks_halted));
    tws_bus_partner peer (.scl(scl), .sda_low(sda_low));

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        if (mismatches == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // one transfer; leaves an idle cycle so psel never toggles in a step
    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            mismatches++;
            stop_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                          input logic [31:0] e);
        apb(a, 1'b0, 32'h0);
        check(rd & m, e);
    endtask

    initial begin
        mismatches = 0;
        compares = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        wait_instruction = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk(tws_pkg::ADDR_STATUS, 32'hFFFFFFFF, 32'h81);
        apb(8'h20, 1'b1, 32'hFF);
        check({31'h0, err}, 32'h1);
        rd_chk(8'h20, 32'hFFFFFFFF, 32'h0);
        apb(tws_pkg::ADDR_SLAVE_ADDR, 1'b1, 32'hA4);
        apb(tws_pkg::ADDR_CONTROL, 1'b1, 32'hC0);
        fork
            begin
                peer.send_start();
                peer.send_byte(8'hA4);
            end
            begin
                repeat (40) @(posedge pclk);
                rd_chk(tws_pkg::ADDR_STATUS, 32'h80, 32'h0);
            end
        join
        repeat (6) @(posedge pclk);
        rd_chk(tws_pkg::ADDR_STATUS, 32'hF6, 32'hE2);
        check({31'h0, bus_irq}, 32'h1);
        // software follows the direction bit
        apb(tws_pkg::ADDR_CONTROL, 1'b1, 32'hC0 | {27'h0, rd[2], 4'h0});
        rd_chk(tws_pkg::ADDR_STATUS, 32'hF6, 32'hA2);
        apb(tws_pkg::ADDR_STATUS, 1'b1, 32'h0);
        rd_chk(tws_pkg::ADDR_STATUS, 32'hF6, 32'hA2);
        apb(tws_pkg::ADDR_STATUS, 1'b1, 32'hFF);
        rd_chk(tws_pkg::ADDR_STATUS, 32'hF6, 32'hA0);
        check({31'h0, bus_irq}, 32'h0);
        apb(tws_pkg::ADDR_CONTROL, 1'b1, 32'hE0);
        rd_chk(tws_pkg::ADDR_STATUS, 32'h12, 32'h12);
        apb(tws_pkg::ADDR_STATUS, 1'b1, 32'hED);
        rd_chk(tws_pkg::ADDR_STATUS, 32'h12, 32'h12);
        apb(tws_pkg::ADDR_STATUS, 1'b1, 32'h10);
        rd_chk(tws_pkg::ADDR_STATUS, 32'h12, 32'h02);
        apb(tws_pkg::ADDR_STATUS, 1'b1, 32'h02);
        apb(tws_pkg::ADDR_CONTROL, 1'b1, 32'hC0);
        peer.send_stop();
        repeat (6) @(posedge pclk);
        rd_chk(tws_pkg::ADDR_STATUS, 32'h20, 32'h0);
        // unrequested stop while we are master loses arbitration
        apb(tws_pkg::ADDR_CONTROL, 1'b1, 32'hE8);
        peer.send_start();
        peer.send_stop();
        repeat (6) @(posedge pclk);
        rd_chk(tws_pkg::ADDR_STATUS, 32'h30, 32'h10);
        apb(tws_pkg::ADDR_STATUS, 1'b1, 32'h12);
        // our released high bit is pulled low by the far side
        apb(tws_pkg::ADDR_DATA, 1'b1, 32'hFF);
        apb(tws_pkg::ADDR_CONTROL, 1'b1, 32'hF0);
        peer.send_start();
        peer.send_byte(8'h00);
        peer.send_stop();
        repeat (6) @(posedge pclk);
        rd_chk(tws_pkg::ADDR_STATUS, 32'h10, 32'h10);
        check({31'h0, sda_out}, 32'h0);
        apb(tws_pkg::ADDR_STATUS, 1'b1, 32'h12);
        apb(tws_pkg::ADDR_EVT_MASK, 1'b1, 32'h1F);
        check({31'h0, evt_irq}, 32'h1);
        apb(tws_pkg::ADDR_EVT_MASK, 1'b1, 32'h0);
        check({31'h0, evt_irq}, 32'h0);
        rd_chk(tws_pkg::ADDR_EVT, 32'h1F, 32'h1F);
        rd_chk(tws_pkg::ADDR_EVT, 32'h1F, 32'h0);
        // general call answered while the cpu waits
        apb(tws_pkg::ADDR_CONTROL, 1'b1, 32'hC2);
        wait_instruction <= 1'b1;
        @(posedge pclk);
        check({31'h0, clocks_halted}, 32'h0);
        peer.send_start();
        peer.send_byte(8'h00);
        repeat (6) @(posedge pclk);
        check({31'h0, bus_irq}, 32'h1);
        rd_chk(tws_pkg::ADDR_STATUS, 32'h40, 32'h40);
        apb(tws_pkg::ADDR_CONTROL, 1'b1, 32'hC6);
        rd_chk(tws_pkg::ADDR_STATUS, 32'h10, 32'h10);
        apb(tws_pkg::ADDR_CONTROL, 1'b1, 32'hC1);
        check({31'h0, clocks_halted}, 32'h1);
        check({31'h0, bus_irq}, 32'h1);
        apb(tws_pkg::ADDR_CONTROL, 1'b1, 32'h81);
        check({31'h0, bus_irq}, 32'h0);
        wait_instruction <= 1'b0;
        peer.send_stop();
        stop_test();
    end
endmodule
